/* cfba_map.vh */
// Address map, field positions and reset values for the fetch and bank core.
`ifndef CFBA_MAP_VH
`define CFBA_MAP_VH

// Program counter geometry.
`define CFBA_PC_W          21
`define CFBA_PC_STEP       21'h000002
`define CFBA_PC_RESET      21'h000000

// Data memory geometry.
`define CFBA_DADDR_W       12
`define CFBA_BANK_W        4
`define CFBA_SFR_BANK      4'hf
`define CFBA_ACCESS_SPLIT  8'h60
`define CFBA_SMALL_BANKS   4'h8

// Core registers that live in the data space.
`define CFBA_BSP_ADDR      12'hfd4
`define CFBA_PCL_ADDR      12'hff9
`define CFBA_BSP_RESET     4'h0

// Two-word instruction marker in the top nibble.
`define CFBA_SECOND_MARK   4'hf

// Opcode patterns.
`define CFBA_OP_LOADBANK   12'h010
`define CFBA_OP_MOVLIT     8'h0e
`define CFBA_OP_RDFILE     6'h14
`define CFBA_OP_WRFILE     7'h37
`define CFBA_OP_BRANCH     5'h1a
`define CFBA_OP_JUMP       8'hef
`define CFBA_OP_CALL       7'h76
`define CFBA_OP_PTRLIT     10'h3b8
`define CFBA_OP_MOVFULL    4'hc

// Instruction field positions.
`define CFBA_ABIT          8
`define CFBA_DBIT          9

`endif

/* cfba_bank_addr.v */
// Data address former: banked, fast-access window or full address.
`timescale 1ns/100ps
`default_nettype none
`include "cfba_map.vh"

module cfba_bank_addr #(
   parameter LARGE_MEM = 1'b1
) (
   // Address sources.
   input  wire        full_sel_i,
   input  wire [11:0] full_addr_i,
   input  wire        access_bit_i,
   input  wire [7:0]  offset_i,
   input  wire [3:0]  bank_i,
   // Resolved address.
   output reg  [11:0] addr_o,
   output wire        impl_o
);

   // Pick the bank: full address, pointer bank, or window half.
   always @* begin
      if (full_sel_i) begin
         addr_o = full_addr_i;
      end else if (access_bit_i) begin
         addr_o = {bank_i, offset_i};
      end else if (offset_i < `CFBA_ACCESS_SPLIT) begin
         addr_o = {4'h0, offset_i};
      end else begin
         addr_o = {`CFBA_SFR_BANK, offset_i};
      end
   end

   // Small parts carry banks 0 to 7 plus the register area of bank 15.
   assign impl_o = LARGE_MEM ? 1'b1 :
                   ((addr_o[11:8] < `CFBA_SMALL_BANKS) ||
                    ((addr_o[11:8] == `CFBA_SFR_BANK) &&
                     (addr_o[7:0] >= `CFBA_ACCESS_SPLIT)));

endmodule
`default_nettype wire

/* cfba_core.v */
// Instruction fetch, two-word decode and data bank addressing core.
// Operation
// - Instructions sit word aligned, low byte even.
// - Counter steps by two, low bit zero.
// - Absolute jump target loads counter bits 20:1.
// - Branch offset counts single-word instructions.
// - Second words carry 1111 plus 12 literal bits.
// - Lone second word executes as a no-operation.
// - Data address is 12 bits, 16 banks.
// - Small parts have 8 banks; large have all.
// - Unimplemented locations read back as zero.
// - Fast window reaches bank zero and registers.
// - Pointer gives upper four, instruction lower eight.
// - Bank pointer upper nibble reads zero, ignores writes.
// - Load bank literal sets the bank pointer.
// - Unimplemented bank writes dropped; flags still update.
// - Full-address move ignores the bank pointer.
// - Other data instructions use pointer or window.
// - Bank 15 offset F9 write changes program flow.
// - Access bit zero uses the fast window.
// - Access bit one uses pointer bank plus offset.
// - Window 00-5F bank zero, 60-FF bank fifteen.
// - Operands read second phase, results written fourth.
`timescale 1ns/100ps
`default_nettype none
`include "cfba_map.vh"

module cfba_core #(
   parameter LARGE_MEM = 1'b1
) (
   // Clock and reset.
   input  wire        sys_clk_i,
   input  wire        resetn_i,
   // Program memory.
   output wire [20:0] prog_addr_o,
   input  wire [15:0] prog_data_i,
   // Data memory.
   output wire [11:0] ram_addr_o,
   output wire        ram_rd_o,
   output wire        ram_wr_o,
   output wire [7:0]  ram_wdata_o,
   input  wire [7:0]  ram_rdata_i,
   // Pointer load from the load pointer literal instruction.
   output wire        ptr_load_o,
   output wire [1:0]  ptr_sel_o,
   output wire [11:0] ptr_value_o,
   // Core state.
   output wire [7:0]  bank_select_pointer_o,
   output wire [7:0]  work_o,
   output wire        zero_flag_o,
   output wire [1:0]  phase_o
);

   // Quarter phases of one instruction cycle.
   localparam [1:0] PH_Q1 = 2'd0;
   localparam [1:0] PH_Q2 = 2'd1;
   localparam [1:0] PH_Q3 = 2'd2;
   localparam [1:0] PH_Q4 = 2'd3;

   reg  [1:0]  phase_q;
   reg  [20:0] pc_q;
   reg  [15:0] ir_q;
   reg         ir_valid_q;
   reg  [15:0] first_q;
   reg         second_pend_q;
   reg  [3:0]  bsp_q;
   reg  [7:0]  work_q;
   reg         zero_q;
   reg  [7:0]  tmp_q;
   reg  [11:0] addr_q;
   reg         impl_q;
   reg         rd_q;
   reg         wr_q;
   reg  [7:0]  wdata_q;
   reg         ptr_load_q;
   reg  [1:0]  ptr_sel_q;
   reg  [11:0] ptr_value_q;
   reg  [11:0] addr_d;
   reg         impl_d;
   reg         full_sel;
   reg  [20:0] pc_d;
   reg         flush;
   wire [11:0] bank_addr;
   wire        bank_impl;
   wire        hit_bsp;
   wire        hit_pcl;
   wire [7:0]  rd_val;

   // Decode of the word in the instruction register.
   wire ir_act    = ir_valid_q & ~second_pend_q;
   wire is_lbank  = ir_act & (ir_q[15:4] == `CFBA_OP_LOADBANK);
   wire is_movlit = ir_act & (ir_q[15:8] == `CFBA_OP_MOVLIT);
   wire is_rdfile = ir_act & (ir_q[15:10] == `CFBA_OP_RDFILE);
   wire is_wrfile = ir_act & (ir_q[15:9] == `CFBA_OP_WRFILE);
   wire is_branch = ir_act & (ir_q[15:11] == `CFBA_OP_BRANCH);
   wire is_jump1  = ir_act & (ir_q[15:8] == `CFBA_OP_JUMP);
   wire is_call1  = ir_act & (ir_q[15:9] == `CFBA_OP_CALL);
   wire is_ptr1   = ir_act & (ir_q[15:6] == `CFBA_OP_PTRLIT);
   wire is_mfull1 = ir_act & (ir_q[15:12] == `CFBA_OP_MOVFULL);
   wire two_first = is_jump1 | is_call1 | is_ptr1 | is_mfull1;

   // A marked word only acts when it follows its own first word.
   wire sec_ok   = ir_valid_q & second_pend_q &
                   (ir_q[15:12] == `CFBA_SECOND_MARK);
   wire sec_jump = sec_ok & ((first_q[15:8] == `CFBA_OP_JUMP) |
                             (first_q[15:9] == `CFBA_OP_CALL));
   wire sec_mov  = sec_ok & (first_q[15:12] == `CFBA_OP_MOVFULL);
   wire sec_ptr  = sec_ok & (first_q[15:6] == `CFBA_OP_PTRLIT);

   // Data access demands of this instruction.
   wire need_rd  = is_rdfile | is_mfull1;
   wire need_wr  = (is_rdfile & ir_q[`CFBA_DBIT]) | is_wrfile | sec_mov;

   // Signed branch displacement in bytes.
   wire [20:0] br_disp = {{9{ir_q[10]}}, ir_q[10:0], 1'b0};

   // Banked or window address from the low-order operand.
   cfba_bank_addr #(
      .LARGE_MEM (LARGE_MEM)
   ) u_bank_addr (
      .full_sel_i   (full_sel),
      .full_addr_i  (ir_q[11:0]),
      .access_bit_i (ir_q[`CFBA_ABIT]),
      .offset_i     (ir_q[7:0]),
      .bank_i       (bsp_q),
      .addr_o       (bank_addr),
      .impl_o       (bank_impl)
   );

   // Address for the read in the second phase or write in the fourth.
   always @* begin
      full_sel = 1'b0;
      addr_d   = addr_q;
      impl_d   = impl_q;
      if (phase_q == PH_Q1 || phase_q == PH_Q3) begin
         full_sel = is_mfull1 | sec_mov;
         addr_d   = bank_addr;
         impl_d   = bank_impl;
      end
   end

   // Core registers decoded out of the data space.
   assign hit_bsp = (addr_q == `CFBA_BSP_ADDR);
   assign hit_pcl = (addr_q == `CFBA_PCL_ADDR);

   // Read value, with zeros from any location that is not there.
   assign rd_val = hit_bsp ? {4'h0, bsp_q} :
                   hit_pcl ? pc_q[7:0] :
                   impl_q  ? ram_rdata_i : 8'h00;

   // Next program counter and pipeline flush at the fourth phase.
   always @* begin
      pc_d  = pc_q + `CFBA_PC_STEP;
      flush = 1'b0;
      if (sec_jump) begin
         pc_d  = {ir_q[11:0], first_q[7:0], 1'b0};
         flush = 1'b1;
      end else if (is_branch) begin
         pc_d  = pc_q + br_disp;
         flush = 1'b1;
      end else if (wr_q && hit_pcl) begin
         pc_d  = {pc_q[20:8], wdata_q[7:1], 1'b0};
         flush = 1'b1;
      end
   end

   // Phase counter, fetch and execute.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase_q       <= PH_Q1;
         pc_q          <= `CFBA_PC_RESET;
         ir_q          <= 16'h0000;
         ir_valid_q    <= 1'b0;
         first_q       <= 16'h0000;
         second_pend_q <= 1'b0;
         bsp_q         <= `CFBA_BSP_RESET;
         work_q        <= 8'h00;
         zero_q        <= 1'b0;
         tmp_q         <= 8'h00;
         addr_q        <= 12'h000;
         impl_q        <= 1'b0;
         rd_q          <= 1'b0;
         wr_q          <= 1'b0;
         wdata_q       <= 8'h00;
         ptr_load_q    <= 1'b0;
         ptr_sel_q     <= 2'h0;
         ptr_value_q   <= 12'h000;
      end else begin
         phase_q    <= phase_q + 2'd1;
         addr_q     <= addr_d;
         impl_q     <= impl_d;
         ptr_load_q <= 1'b0;
         case (phase_q)
            PH_Q1: begin
               rd_q <= need_rd;
            end
            PH_Q2: begin
               rd_q <= 1'b0;
               if (rd_q) begin
                  tmp_q <= rd_val;
               end
            end
            PH_Q3: begin
               wr_q <= need_wr;
               if (is_wrfile) begin
                  wdata_q <= work_q;
               end else begin
                  wdata_q <= tmp_q;
               end
            end
            PH_Q4: begin
               wr_q          <= 1'b0;
               pc_q          <= pc_d;
               ir_q          <= prog_data_i;
               ir_valid_q    <= ~flush;
               second_pend_q <= two_first;
               if (two_first) begin
                  first_q <= ir_q;
               end
               if (is_lbank) begin
                  bsp_q <= ir_q[3:0];
               end else if (wr_q && hit_bsp) begin
                  bsp_q <= wdata_q[3:0];
               end
               if (is_movlit) begin
                  work_q <= ir_q[7:0];
               end else if (is_rdfile && !ir_q[`CFBA_DBIT]) begin
                  work_q <= tmp_q;
               end
               if (is_rdfile) begin
                  zero_q <= (tmp_q == 8'h00);
               end
               if (sec_ptr) begin
                  ptr_load_q  <= 1'b1;
                  ptr_sel_q   <= first_q[5:4];
                  ptr_value_q <= {first_q[3:0], ir_q[7:0]};
               end
            end
            default: begin
               rd_q <= 1'b0;
            end
         endcase
      end
   end

   // Strobes reach the memory only for locations that exist.
   assign ram_rd_o    = rd_q & impl_q & ~hit_bsp & ~hit_pcl;
   assign ram_wr_o    = wr_q & impl_q & ~hit_bsp & ~hit_pcl;
   assign ram_addr_o  = addr_q;
   assign ram_wdata_o = wdata_q;
   assign prog_addr_o = pc_q;

   // State outputs.
   assign bank_select_pointer_o = {4'h0, bsp_q};
   assign work_o      = work_q;
   assign zero_flag_o = zero_q;
   assign phase_o     = phase_q;
   assign ptr_load_o  = ptr_load_q;
   assign ptr_sel_o   = ptr_sel_q;
   assign ptr_value_o = ptr_value_q;

endmodule
`default_nettype wire

/* cfba_core_chk.sv */
// Concurrent checks on the ports of the fetch and bank core.
`timescale 1ns/100ps
`default_nettype none
module cfba_core_chk (
   // Clock and reset.
   input wire logic        sys_clk_i,
   input wire logic        resetn_i,
   // Observed outputs.
   input wire logic [20:0] prog_addr_o,
   input wire logic [11:0] ram_addr_o,
   input wire logic        ram_rd_o,
   input wire logic        ram_wr_o,
   input wire logic        ptr_load_o,
   input wire logic [7:0]  bank_select_pointer_o,
   input wire logic [1:0]  phase_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   // A read holds its address into the phase where data is taken.
   sequence s_read_hold;
      ##1 (phase_o == 2'h2 && $stable(ram_addr_o));
   endsequence

   // A strobe drops for the other three phases of the cycle.
   sequence s_strobe_gap(sig);
      ##1 !sig ##1 !sig ##1 !sig;
   endsequence

   a_pc_word_aligned: assert property (prog_addr_o[0] == 1'b0)
      else $error("fetch address is odd");
   // The first edge out of reset has no advance behind it yet.
   a_phase_advance: assert property ($past(resetn_i) |->
      phase_o == $past(phase_o) + 2'h1)
      else $error("quarter phase did not advance by one");
   a_read_phase: assert property (ram_rd_o |-> phase_o == 2'h1)
      else $error("read strobe outside second phase");
   a_write_phase: assert property (ram_wr_o |-> phase_o == 2'h3)
      else $error("write strobe outside fourth phase");
   a_read_addr_hold: assert property (ram_rd_o |-> s_read_hold)
      else $error("read address moved before data was taken");
   a_write_once: assert property (ram_wr_o |-> s_strobe_gap(ram_wr_o))
      else $error("write strobe longer than one phase");
   a_bank_upper_zero: assert property (bank_select_pointer_o[7:4] == 4'h0)
      else $error("bank pointer upper nibble not zero");
   a_bank_step_edge: assert property (!$stable(bank_select_pointer_o) |-> phase_o == 2'h0)
      else $error("bank pointer changed mid cycle");
   a_pc_step_edge: assert property (!$stable(prog_addr_o) |-> phase_o == 2'h0)
      else $error("fetch address changed mid cycle");
   a_core_reg_write: assert property (ram_wr_o |-> ram_addr_o != 12'hfd4 && ram_addr_o != 12'hff9)
      else $error("core register write reached data memory");
   a_ptr_pulse: assert property (ptr_load_o |-> phase_o == 2'h0)
      else $error("pointer load pulse outside first phase");
endmodule

bind cfba_core cfba_core_chk u_chk (
   .sys_clk_i             (sys_clk_i),
   .resetn_i              (resetn_i),
   .prog_addr_o           (prog_addr_o),
   .ram_addr_o            (ram_addr_o),
   .ram_rd_o              (ram_rd_o),
   .ram_wr_o              (ram_wr_o),
   .ptr_load_o            (ptr_load_o),
   .bank_select_pointer_o (bank_select_pointer_o),
   .phase_o               (phase_o)
);
`default_nettype wire

/* cfba_mem_model.sv */
// Program memory and static data memory that sit beside the core.
`timescale 1ns/100ps
`default_nettype none
module cfba_mem_model (
   // Clock.
   input  wire logic        sys_clk_i,
   // Program side.
   input  wire logic [20:0] prog_addr_i,
   output wire logic [15:0] prog_data_o,
   // Data side.
   input  wire logic [11:0] ram_addr_i,
   input  wire logic        ram_rd_i,
   input  wire logic        ram_wr_i,
   input  wire logic [7:0]  ram_wdata_i,
   output wire logic [7:0]  ram_rdata_o
);
   logic [15:0] prog [0:255];
   logic [7:0]  ram  [0:4095];
   logic [7:0]  fill_q = 8'h5a;

   // Words are picked by the word address, so the low byte sits even.
   assign prog_data_o = prog[prog_addr_i[8:1]];
   // Read data is valid only under the strobe; otherwise a moving pattern.
   assign ram_rdata_o = ram_rd_i ? ram[ram_addr_i] : fill_q;
   // Writes land at the edge closing the write phase.
   always @(posedge sys_clk_i) begin
      fill_q <= ~fill_q;
      if (ram_wr_i) begin
         ram[ram_addr_i] <= ram_wdata_i;
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Program-driven test of fetch, two-word decode and bank addressing.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        sys_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   wire  [20:0] prog_addr_o;
   wire  [15:0] prog_data_i;
   wire  [11:0] ram_addr_o;
   wire         ram_rd_o;
   wire         ram_wr_o;
   wire  [7:0]  ram_wdata_o;
   wire  [7:0]  ram_rdata_i;
   wire  [7:0]  bank_select_pointer_o;
   wire  [7:0]  work_o;
   wire         zero_flag_o;
   int          bad_count = 0;
   int          num_checks = 0;
   int          n;
   // Bank 3 set, literal stored banked, low window, high window, then the
   // pointer written through its data address, a read back, a full move,
   // a jump over two words, a lone second word and a self branch.
   localparam logic [15:0] PROG [0:15] = '{
      16'h0103, 16'h0e5a, 16'h6f20, 16'h6e10, 16'h6e70, 16'h0ef3,
      16'h6ed4, 16'h5010, 16'hc123, 16'hf456, 16'hef0e, 16'hf000,
      16'h0e11, 16'h6e30, 16'hf999, 16'hd7ff};

   cfba_core dut (
      .sys_clk_i             (sys_clk_i),
      .resetn_i              (resetn_i),
      .prog_addr_o           (prog_addr_o),
      .prog_data_i           (prog_data_i),
      .ram_addr_o            (ram_addr_o),
      .ram_rd_o              (ram_rd_o),
      .ram_wr_o              (ram_wr_o),
      .ram_wdata_o           (ram_wdata_o),
      .ram_rdata_i           (ram_rdata_i),
      .ptr_load_o            (),
      .ptr_sel_o             (),
      .ptr_value_o           (),
      .bank_select_pointer_o (bank_select_pointer_o),
      .work_o                (work_o),
      .zero_flag_o           (zero_flag_o),
      .phase_o               ()
   );

   cfba_mem_model u_mem (
      .sys_clk_i   (sys_clk_i),
      .prog_addr_i (prog_addr_o),
      .prog_data_o (prog_data_i),
      .ram_addr_i  (ram_addr_o),
      .ram_rd_i    (ram_rd_o),
      .ram_wr_i    (ram_wr_o),
      .ram_wdata_i (ram_wdata_o),
      .ram_rdata_o (ram_rdata_i)
   );

   // The clock runs at 20 MHz.
   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // Compares one byte and counts the outcome.
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Loads the memories, releases reset and checks the final state.
   initial begin
      for (n = 0; n < 4096; n++) u_mem.ram[n] = 8'h00;
      for (n = 0; n < 256; n++) u_mem.prog[n] = (n < 16) ? PROG[n] : 16'h0000;
      u_mem.ram[12'h123] = 8'h77;
      repeat (5) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      for (n = 0; n < 400 && prog_addr_o !== 21'h000020; n++) begin
         @(posedge sys_clk_i);
      end
      if (n == 400) begin
         bad_count++;
         $display("CHECK FAILED at %0t: program never reached its loop", $time);
         complete_run();
      end else begin
         repeat (8) @(posedge sys_clk_i);
         #5;
         check8(u_mem.ram[12'h320], 8'h5a);
         check8(u_mem.ram[12'h010], 8'h5a);
         check8(u_mem.ram[12'hf70], 8'h5a);
         check8(u_mem.ram[12'hfd4], 8'h00);
         check8(bank_select_pointer_o, 8'h03);
         check8(work_o, 8'h5a);
         check8({7'h00, zero_flag_o}, 8'h00);
         check8(u_mem.ram[12'h456], 8'h77);
         check8(u_mem.ram[12'h030], 8'h00);
         check8({7'h00, prog_addr_o[0]}, 8'h00);
         complete_run();
      end
   end
endmodule
`default_nettype wire
